// ===== core/vector_placement.v
`timescale 1ns/100ps
`default_nettype none
`include "vector_map.vh"

module vector_placement (
   input  wire                   clock,
   input  wire                   resetn,
   input  wire                   boot_reset_fuse,
   input  wire                   large_variant,
   input  wire                   vector_base_select,
   input  wire                   global_enable,
   input  wire                   irq_accept,
   input  wire                   irq_return,
   input  wire                   external_request_zero,
   input  wire                   external_request_one,
   input  wire                   pin_change_request_zero,
   input  wire                   pin_change_request_one,
   input  wire                   pin_change_request_two,
   input  wire                   watchdog_timeout_event,
   input  wire                   timer2_compare_match_a,
   input  wire                   timer2_compare_match_b,
   input  wire                   timer2_counter_overflow,
   input  wire                   timer1_capture_event,
   input  wire                   timer1_compare_match_a,
   input  wire                   timer1_compare_match_b,
   input  wire                   timer1_counter_overflow,
   input  wire                   timer0_compare_match_a,
   input  wire                   timer0_compare_match_b,
   input  wire                   timer0_counter_overflow,
   input  wire                   serial_transfer_complete,
   input  wire                   serial_rx_complete,
   input  wire                   tx_buffer_empty,
   input  wire                   serial_tx_complete,
   input  wire                   conversion_complete,
   input  wire                   eeprom_ready_event,
   input  wire                   comparator_event,
   input  wire                   two_wire_serial_event,
   input  wire                   program_store_ready,
   input  wire [`SRC_COUNT-1:0]  source_enable,
   output wire                   start_valid,
   output wire [`ADDR_W-1:0]     start_address,
   output wire                   irq_valid,
   output wire [`ADDR_W-1:0]     vector_address,
   output wire [`NUM_W-1:0]      vector_number,
   output wire [`SRC_COUNT-1:0]  source_ack,
   output wire                   in_service
);

   // ------------------------------------------------------------
   // states
   // ------------------------------------------------------------
   localparam [4:0] ST_SETTLE  = 5'h01;
   localparam [4:0] ST_START   = 5'h02;
   localparam [4:0] ST_IDLE    = 5'h04;
   localparam [4:0] ST_OFFER   = 5'h08;
   localparam [4:0] ST_SERVICE = 5'h10;

   // ------------------------------------------------------------
   // nominal two-word table
   // ------------------------------------------------------------
   function [`ADDR_W-1:0] nominal_address;
      input [`SRC_IDX_W-1:0] src;
      begin
         case (src)
            5'h00: nominal_address = `VEC_EXT0;
            5'h01: nominal_address = `VEC_EXT1;
            5'h02: nominal_address = `VEC_PC0;
            5'h03: nominal_address = `VEC_PC1;
            5'h04: nominal_address = `VEC_PC2;
            5'h05: nominal_address = `VEC_WDOG;
            5'h06: nominal_address = `VEC_T2_CMPA;
            5'h07: nominal_address = `VEC_T2_CMPB;
            5'h08: nominal_address = `VEC_T2_WRAP;
            5'h09: nominal_address = `VEC_T1_CAPTURE;
            5'h0a: nominal_address = `VEC_T1_CMPA;
            5'h0b: nominal_address = `VEC_T1_CMPB;
            5'h0c: nominal_address = `VEC_T1_WRAP;
            5'h0d: nominal_address = `VEC_T0_CMPA;
            5'h0e: nominal_address = `VEC_T0_CMPB;
            5'h0f: nominal_address = `VEC_T0_WRAP;
            5'h10: nominal_address = `VEC_SER_DONE;
            5'h11: nominal_address = `VEC_RX_DONE;
            5'h12: nominal_address = `VEC_TX_EMPTY;
            5'h13: nominal_address = `VEC_TX_DONE;
            5'h14: nominal_address = `VEC_CONV_DONE;
            5'h15: nominal_address = `VEC_EEP_READY;
            5'h16: nominal_address = `VEC_COMPARATOR;
            5'h17: nominal_address = `VEC_TWO_WIRE;
            5'h18: nominal_address = `VEC_STORE_READY;
            default: nominal_address = `RESET_ADDR;
         endcase
      end
   endfunction

   // ------------------------------------------------------------
   // strap synchronisation
   // ------------------------------------------------------------
   wire [1:0] strap_sync;

   sync_two_stage #(
      .WIDTH (2)
   ) u_strap_sync (
      .clock    (clock),
      .resetn   (resetn),
      .async_in ({large_variant, boot_reset_fuse}),
      .sync_out (strap_sync)
   );

   // ------------------------------------------------------------
   // request gathering
   // ------------------------------------------------------------
   wire [`SRC_COUNT-1:0] pending;
   wire [`SRC_COUNT-1:0] eligible;

   assign pending = {program_store_ready,      two_wire_serial_event,
                     comparator_event,         eeprom_ready_event,
                     conversion_complete,      serial_tx_complete,
                     tx_buffer_empty,          serial_rx_complete,
                     serial_transfer_complete, timer0_counter_overflow,
                     timer0_compare_match_b,   timer0_compare_match_a,
                     timer1_counter_overflow,  timer1_compare_match_b,
                     timer1_compare_match_a,   timer1_capture_event,
                     timer2_counter_overflow,  timer2_compare_match_b,
                     timer2_compare_match_a,   watchdog_timeout_event,
                     pin_change_request_two,   pin_change_request_one,
                     pin_change_request_zero,  external_request_one,
                     external_request_zero};

   assign eligible = pending & source_enable;

   reg [`SRC_IDX_W-1:0] winner;
   reg                  any_eligible;
   integer              i;

   always @* begin
      winner       = 5'h00;
      any_eligible = 1'b0;
      for (i = `SRC_COUNT - 1; i >= 0; i = i - 1) begin
         if (eligible[i]) begin
            winner       = i[`SRC_IDX_W-1:0];
            any_eligible = 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   reg [4:0]              state_reg;
   reg [4:0]              state_next;
   reg [`SETTLE_W-1:0]    settle_reg;
   reg                    fuse_reg;
   reg                    large_reg;
   reg                    start_valid_reg;
   reg [`ADDR_W-1:0]      start_address_reg;
   reg [`ADDR_W-1:0]      vector_address_reg;
   reg [`NUM_W-1:0]       vector_number_reg;
   reg [`SRC_IDX_W-1:0]   source_reg;
   reg [`SRC_COUNT-1:0]   source_ack_reg;

   // ------------------------------------------------------------
   // address arithmetic
   // ------------------------------------------------------------
   wire [`ADDR_W-1:0] boot_base;
   wire [`ADDR_W-1:0] nominal_entry;
   wire [`ADDR_W-1:0] table_entry;
   wire [`ADDR_W-1:0] placed_entry;
   wire [`ADDR_W-1:0] reset_target;

   assign boot_base = large_reg ? `BOOT_RESET_LARGE : `BOOT_RESET_SMALL;

   assign nominal_entry = nominal_address(winner);

   assign table_entry = large_reg ? nominal_entry
                                  : {1'b0, nominal_entry[`ADDR_W-1:1]};

   assign placed_entry = vector_base_select ? table_entry + boot_base : table_entry;

   assign reset_target = (fuse_reg == `FUSE_PROGRAMMED) ? boot_base : `RESET_ADDR;

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always @* begin
      state_next = state_reg;
      case (state_reg)
         ST_SETTLE: begin
            if (settle_reg == `SETTLE_DONE) begin
               state_next = ST_START;
            end
         end
         ST_START: begin
            state_next = ST_IDLE;
         end
         ST_IDLE: begin
            if (global_enable && any_eligible) begin
               state_next = ST_OFFER;
            end
         end
         ST_OFFER: begin
            if (irq_accept) begin
               state_next = ST_SERVICE;
            end
         end
         ST_SERVICE: begin
            if (irq_return) begin
               state_next = ST_IDLE;
            end
         end
         default: begin
            state_next = ST_SETTLE;
         end
      endcase
   end

   // ------------------------------------------------------------
   // sequential
   // ------------------------------------------------------------
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         state_reg          <= ST_SETTLE;
         settle_reg         <= `SETTLE_CYCLES;
         fuse_reg           <= 1'b1;
         large_reg          <= 1'b1;
         start_valid_reg    <= 1'b0;
         start_address_reg  <= `RESET_ADDR;
         vector_address_reg <= `RESET_ADDR;
         vector_number_reg  <= 5'h00;
         source_reg         <= 5'h00;
         source_ack_reg     <= {`SRC_COUNT{1'b0}};
      end else begin
         state_reg       <= state_next;
         start_valid_reg <= 1'b0;
         source_ack_reg  <= {`SRC_COUNT{1'b0}};
         case (state_reg)
            ST_SETTLE: begin
               // straps caught after synchroniser settles
               if (settle_reg != `SETTLE_DONE) begin
                  settle_reg <= settle_reg - 2'h1;
               end else begin
                  fuse_reg  <= strap_sync[0];
                  large_reg <= strap_sync[1];
               end
            end
            ST_START: begin
               start_valid_reg   <= 1'b1;
               start_address_reg <= reset_target;
            end
            ST_IDLE: begin
               if (global_enable && any_eligible) begin
                  source_reg         <= winner;
                  vector_address_reg <= placed_entry;
                  vector_number_reg  <= winner + `VEC_NUM_BASE;
               end
            end
            ST_OFFER: begin
               if (irq_accept) begin
                  source_ack_reg[source_reg] <= 1'b1;
               end
            end
            default: begin
               source_ack_reg <= {`SRC_COUNT{1'b0}};
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign start_valid    = start_valid_reg;
   assign start_address  = start_address_reg;
   assign irq_valid      = (state_reg == ST_OFFER);
   assign vector_address = vector_address_reg;
   assign vector_number  = vector_number_reg;
   assign source_ack     = source_ack_reg;
   assign in_service     = (state_reg == ST_SERVICE);

endmodule

`default_nettype wire

// ===== inc/vector_map.vh
`ifndef VECTOR_MAP_VH
`define VECTOR_MAP_VH

// ------------------------------------------------------------
// widths and counts
// ------------------------------------------------------------
`define ADDR_W            14
`define NUM_W             5
`define SRC_COUNT         25
`define SRC_IDX_W         5
`define SETTLE_W          2
`define SETTLE_CYCLES     2'h3
`define SETTLE_DONE       2'h0
`define VEC_NUM_BASE      5'h02

// ------------------------------------------------------------
// fuse coding and reset placement
// ------------------------------------------------------------
`define FUSE_PROGRAMMED   1'b0
`define RESET_ADDR        14'h0000
`define BOOT_RESET_SMALL  14'h0c00
`define BOOT_RESET_LARGE  14'h1c00

// ------------------------------------------------------------
// nominal two-word table, vector index 1 to 25
// ------------------------------------------------------------
`define VEC_EXT0          14'h0002
`define VEC_EXT1          14'h0004
`define VEC_PC0           14'h0006
`define VEC_PC1           14'h0008
`define VEC_PC2           14'h000a
`define VEC_WDOG          14'h000c
`define VEC_T2_CMPA       14'h000e
`define VEC_T2_CMPB       14'h0010
`define VEC_T2_WRAP       14'h0012
`define VEC_T1_CAPTURE    14'h0014
`define VEC_T1_CMPA       14'h0016
`define VEC_T1_CMPB       14'h0018
`define VEC_T1_WRAP       14'h001a
`define VEC_T0_CMPA       14'h001c
`define VEC_T0_CMPB       14'h001e
`define VEC_T0_WRAP       14'h0020
`define VEC_SER_DONE      14'h0022
`define VEC_RX_DONE       14'h0024
`define VEC_TX_EMPTY      14'h0026
`define VEC_TX_DONE       14'h0028
`define VEC_CONV_DONE     14'h002a
`define VEC_EEP_READY     14'h002c
`define VEC_COMPARATOR    14'h002e
`define VEC_TWO_WIRE      14'h0030
`define VEC_STORE_READY   14'h0032

`endif

// ===== core/sync_two_stage.v
`timescale 1ns/100ps
`default_nettype none

module sync_two_stage #(
   parameter WIDTH = 2
) (
   input  wire             clock,
   input  wire             resetn,
   input  wire [WIDTH-1:0] async_in,
   output wire [WIDTH-1:0] sync_out
);

   reg [WIDTH-1:0] meta_reg;
   reg [WIDTH-1:0] stable_reg;

   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         meta_reg   <= {WIDTH{1'b1}};
         stable_reg <= {WIDTH{1'b1}};
      end else begin
         meta_reg   <= async_in;
         stable_reg <= meta_reg;
      end
   end

   assign sync_out = stable_reg;

endmodule

`default_nettype wire

// ===== dv/vector_placement_properties.sv
`timescale 1ns/100ps
`default_nettype none
`include "vector_map.vh"
module vector_placement_properties (
   input wire logic        clock,
   input wire logic        resetn,
   input wire logic        boot_reset_fuse,
   input wire logic        large_variant,
   input wire logic        vector_base_select,
   input wire logic        global_enable,
   input wire logic        irq_accept,
   input wire logic        irq_return,
   input wire logic [24:0] source_enable,
   input wire logic        start_valid,
   input wire logic [13:0] start_address,
   input wire logic        irq_valid,
   input wire logic [13:0] vector_address,
   input wire logic [4:0]  vector_number,
   input wire logic [24:0] source_ack,
   input wire logic        in_service
);
   default clocking @(posedge clock); endclocking
   default disable iff (!resetn);
   // ------------------------------------------------
   // helpers
   // ------------------------------------------------
   function automatic logic [13:0] place(logic [4:0] n, logic l, logic s);
      place = (l ? {8'h0, n - 5'h1, 1'b0} : {9'h0, n - 5'h1})
            + (s ? (l ? `BOOT_RESET_LARGE : `BOOT_RESET_SMALL) : 14'h0);
   endfunction
   sequence s_accept;
      irq_valid && irq_accept;
   endsequence
   sequence s_taken;
      in_service && !irq_valid ##0 source_ack == (25'h1 << (vector_number - 5'h2));
   endsequence
   sequence s_return;
      in_service && irq_return;
   endsequence
   // ------------------------------------------------
   // properties
   // ------------------------------------------------
   a_offer_holds:
   assert property (irq_valid && !irq_accept |=> irq_valid && $stable(vector_address))
      else $error("offer dropped or moved");
   a_accept_acks:
   assert property (s_accept |=> s_taken) else $error("accept not acknowledged");
   a_ack_single:
   assert property (|source_ack |=> source_ack == 25'h0) else $error("ack longer than a cycle");
   a_service_holds:
   assert property (in_service && !irq_return |=> in_service && !irq_valid)
      else $error("service left early");
   a_return_idle:
   assert property (s_return |=> !in_service && !irq_valid) else $error("return ignored");
   a_start_once:
   assert property (start_valid |=> !start_valid [*8]) else $error("start repeated");
   a_start_addr:
   assert property (start_valid |-> start_address == (boot_reset_fuse ? 14'h0 :
      (large_variant ? `BOOT_RESET_LARGE : `BOOT_RESET_SMALL))) else $error("bad start");
   a_vector_place:
   assert property ($rose(irq_valid) |-> vector_address ==
      place(vector_number, large_variant, $past(vector_base_select))) else $error("bad vector");
   a_enabled_only:
   assert property ($rose(irq_valid) |-> $past(global_enable) &&
      |($past(source_enable) & (25'h1 << (vector_number - 5'h2)))) else $error("disabled offered");
endmodule
`default_nettype wire

// ===== dv/core_fetch_model.sv
`timescale 1ns/100ps
`default_nettype none
module core_fetch_model (
   input  wire logic       clock,
   input  wire logic       resetn,
   input  wire logic       irq_valid,
   input  wire logic       in_service,
   input  wire logic [3:0] delay,
   output var  logic       irq_accept,
   output var  logic       irq_return
);
   logic [3:0] wait_cnt;
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         irq_accept <= 1'b0;
         irq_return <= 1'b0;
         wait_cnt   <= 4'h0;
      end else begin
         irq_accept <= 1'b0;
         irq_return <= 1'b0;
         if (irq_accept || irq_return || !(irq_valid || in_service)) begin
            wait_cnt <= 4'h0;
         end else if (wait_cnt >= delay) begin
            irq_accept <= irq_valid;
            irq_return <= in_service;
            wait_cnt   <= 4'h0;
         end else begin
            wait_cnt <= wait_cnt + 4'h1;
         end
      end
   end
endmodule
`default_nettype wire

// ===== dv/vector_placement_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "vector_map.vh"
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin fail_count++; \
   $display("MISMATCH %s exp %h got %h", n, e, g); end end
module vector_placement_tb;
   logic        clock = 1'b0;
   logic        resetn = 1'b0;
   logic        boot_reset_fuse = 1'b1;
   logic        large_variant = 1'b1;
   logic        vector_base_select = 1'b0;
   logic        global_enable = 1'b0;
   logic [24:0] req = 25'h0;
   logic [24:0] source_enable = 25'h0;
   logic [3:0]  delay = 4'h0;
   logic        irq_accept, irq_return, irq_valid, in_service, start_valid;
   logic [13:0] start_address, vector_address;
   logic [4:0]  vector_number;
   logic [24:0] source_ack;
   logic [18:0] exp_q[$];
   logic [18:0] exp_head;
   int          fail_count = 0;
   int          check_count = 0;
   int          c, seed_v;
   always #25 clock = ~clock;
   vector_placement dut (
      .clock, .resetn, .boot_reset_fuse, .large_variant, .vector_base_select,
      .global_enable, .irq_accept, .irq_return, .source_enable, .start_valid,
      .start_address, .irq_valid, .vector_address, .vector_number, .source_ack, .in_service,
      .external_request_zero(req[0]), .external_request_one(req[1]),
      .pin_change_request_zero(req[2]), .pin_change_request_one(req[3]),
      .pin_change_request_two(req[4]), .watchdog_timeout_event(req[5]),
      .timer2_compare_match_a(req[6]), .timer2_compare_match_b(req[7]),
      .timer2_counter_overflow(req[8]), .timer1_capture_event(req[9]),
      .timer1_compare_match_a(req[10]), .timer1_compare_match_b(req[11]),
      .timer1_counter_overflow(req[12]), .timer0_compare_match_a(req[13]),
      .timer0_compare_match_b(req[14]), .timer0_counter_overflow(req[15]),
      .serial_transfer_complete(req[16]), .serial_rx_complete(req[17]),
      .tx_buffer_empty(req[18]), .serial_tx_complete(req[19]),
      .conversion_complete(req[20]), .eeprom_ready_event(req[21]),
      .comparator_event(req[22]), .two_wire_serial_event(req[23]),
      .program_store_ready(req[24])
   );
   core_fetch_model core (.clock, .resetn, .irq_valid, .in_service, .delay, .irq_accept,
      .irq_return);
   // ------------------------------------------------
   // tasks
   // ------------------------------------------------
   task automatic stop_test;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   function automatic logic [13:0] vec(int k);
      vec = (large_variant ? 14'(2 * (k + 1)) : 14'(k + 1))
          + (vector_base_select ? (large_variant ? `BOOT_RESET_LARGE : `BOOT_RESET_SMALL) : 14'h0);
   endfunction
   task automatic do_reset(input logic f, input logic l);
      int          i;
      logic [13:0] exp_start;
      @(posedge clock);
      resetn <= 1'b0;
      boot_reset_fuse <= f;
      large_variant <= l;
      repeat (20) @(posedge clock);
      resetn <= 1'b1;
      for (i = 0; i < 20 && start_valid !== 1'b1; i++) @(negedge clock);
      `CHK("start_valid", 1'b1, start_valid)
      exp_start = f ? `RESET_ADDR : (l ? `BOOT_RESET_LARGE : `BOOT_RESET_SMALL);
      `CHK("start_address", exp_start, start_address)
      if (start_valid !== 1'b1) stop_test();
   endtask
   task automatic serve(input logic [24:0] bits, input logic [24:0] en, input logic sel);
      int i, k;
      @(posedge clock);
      global_enable <= 1'b0;
      source_enable <= en;
      vector_base_select <= sel;
      req <= bits;
      repeat (8) @(posedge clock);
      @(negedge clock);
      `CHK("masked offer", 1'b0, irq_valid)
      for (k = 0; k < 25; k++) if (bits[k] & en[k]) exp_q.push_back({5'(k + 2), vec(k)});
      @(posedge clock);
      global_enable <= 1'b1;
      for (i = 0; i < 2000 && (req & source_enable) != 25'h0; i++) begin
         @(posedge clock);
         req <= req & ~source_ack;
         delay <= 4'($urandom);
      end
      for (i = 0; i < 40 && (in_service | irq_valid) !== 1'b0; i++) @(negedge clock);
      `CHK("left over", 32'h0, exp_q.size())
      `CHK("idle", 1'b0, in_service | irq_valid)
      if (fail_count > 0) stop_test();
   endtask
   // ------------------------------------------------
   // offered vectors against notes
   // ------------------------------------------------
   always @(posedge clock) begin
      if (resetn && irq_valid && irq_accept) begin
         exp_head = (exp_q.size() > 0) ? exp_q.pop_front() : 19'h0;
         `CHK("vector", exp_head, {vector_number, vector_address})
      end
   end
   initial begin
      seed_v = $urandom(32'he96a);
      for (c = 0; c < 8; c++) begin
         do_reset(c[0], c[1]);
         serve(c < 4 ? 25'h1ffffff : 25'($urandom), c < 4 ? 25'h1ffffff : 25'($urandom), c[2]);
      end
      stop_test();
   end
endmodule
bind vector_placement vector_placement_properties chk (.clock, .resetn, .boot_reset_fuse,
   .large_variant, .vector_base_select, .global_enable, .irq_accept, .irq_return,
   .source_enable, .start_valid, .start_address, .irq_valid, .vector_address,
   .vector_number, .source_ack, .in_service);
`default_nettype wire
